// ### clock_sync_serial_channel.sv
// Clock-synchronous serial channel: 8-bit shifter, transfer clock, flow control.
// Assumes control bits come from logic on clk_sys_in; pins are asynchronous.
`default_nettype none
module clock_sync_serial_channel #(
   parameter int DATA_W = serial_channel_pkg::CHAR_BITS,
   parameter int FIFO_DEPTH = serial_channel_pkg::TX_FIFO_DEPTH
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire serial_channel_pkg::ctrl_s ctrl_in,
   input wire logic [7:0] bit_rate_divider_in,
   input wire logic count_source_tick_in,
   input wire logic tx_write_valid_in,
   input wire logic [DATA_W-1:0] tx_write_data_in,
   output logic tx_write_ready_out,
   input wire logic rx_read_in,
   output logic [DATA_W-1:0] rx_buffer_out,
   input wire logic tx_irq_clear_in,
   input wire logic rx_irq_clear_in,
   output serial_channel_pkg::status_s status_out,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_out,
   output logic serial_clock_alt_out,
   output logic serial_clock_alt_oe_out,
   output logic serial_out_pin_out,
   input wire logic serial_in_pin_in,
   input wire logic flow_control_pin_in,
   output logic flow_control_pin_out,
   output logic flow_control_pin_oe_out,
   input wire logic flow_cts_alt_in,
   output logic flow_peer_disable_out
);
   import serial_channel_pkg::*;

   logic rst_meta_reg, rst_sync_reg, rst_n;
   logic [3:0] sync1_reg, sync2_reg;
   xfer_state_e state_reg, state_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] div_cnt_reg, div_cnt_next;
   logic clk_act_reg, clk_act_next, sampled_reg, sampled_next;
   logic [DATA_W-1:0] tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next;
   logic [DATA_W-1:0] rx_buf_reg, rx_buf_next, load_data;
   logic serial_out_reg, serial_out_next, rts_reg, rts_next;
   logic rx_complete_reg, rx_complete_next, overrun_reg, overrun_next;
   logic tx_irq_reg, tx_irq_next, rx_irq_reg, rx_irq_next;
   logic rrm_pending_reg, rrm_pending_next;
   logic ext_act_prev_reg, pin_prev_reg;
   logic fifo_valid, fifo_pop;
   logic [DATA_W-1:0] fifo_data;
   logic mode_on, internal, data_present, cts_used, cts_high, rts_used, start_ok;
   logic ext_act, half_done, drive_evt, sample_evt, gen_level, pin_level, pin_fall;
   logic alt_route;

   // Pick the shifter bit for a given count in the selected order
   function automatic logic [2:0] bit_index(input logic [2:0] cnt, input logic msb_first);
      bit_index = msb_first ? 3'(LAST_BIT_COUNT - cnt) : cnt;
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // Pin synchronisers: {cts alt, flow pin, clock pin, data in}; only stage two is read
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= SYNC_RESET;
         sync2_reg <= SYNC_RESET;
      end else begin
         sync1_reg <= {flow_cts_alt_in, flow_control_pin_in, serial_clock_pin_in,
                       serial_in_pin_in};
         sync2_reg <= sync1_reg;
      end
   end

   tx_word_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n),
      .flush_in(!mode_on),
      .in_valid_in(tx_write_valid_in),
      .in_data_in(tx_write_data_in),
      .in_ready_out(tx_write_ready_out),
      .out_valid_out(fifo_valid),
      .out_data_out(fifo_data),
      .out_ready_in(fifo_pop)
   );

   // Qualifiers and edge events
   always_comb begin
      mode_on = (ctrl_in.serial_mode_field == MODE_SYNC);
      internal = !ctrl_in.clock_source_dir;
      data_present = fifo_valid || rrm_pending_reg;
      cts_used = !ctrl_in.flow_ctrl_disable &&
                 (ctrl_in.split_flow_pins_sel || !ctrl_in.flow_ctrl_dir_sel);
      cts_high = ctrl_in.split_flow_pins_sel ? sync2_reg[3] : sync2_reg[2];
      rts_used = !ctrl_in.flow_ctrl_disable && ctrl_in.flow_ctrl_dir_sel;
      // Continuous-mode dummy starts only when reception is enabled
      start_ok = mode_on && (state_reg == ST_IDLE) && ctrl_in.tx_enable && data_present &&
                 !(cts_used && cts_high) &&
                 (fifo_valid || ctrl_in.rx_enable);
      fifo_pop = start_ok && fifo_valid;
      load_data = fifo_valid ? (fifo_data ^ {DATA_W{ctrl_in.data_invert_sel}}) :
                  DUMMY_TX_DATA;
      ext_act = ctrl_in.clock_polarity_sel ? sync2_reg[1] : !sync2_reg[1];
      half_done = internal && count_source_tick_in &&
                  (div_cnt_reg == bit_rate_divider_in);
      drive_evt = (state_reg == ST_SHIFT) &&
                  (internal ? (half_done && !clk_act_reg) : (ext_act && !ext_act_prev_reg));
      sample_evt = (state_reg == ST_SHIFT) &&
                   (internal ? (half_done && clk_act_reg) : (!ext_act && ext_act_prev_reg));
      gen_level = ctrl_in.clock_polarity_sel ? clk_act_reg : !clk_act_reg;
      pin_level = internal ? gen_level : sync2_reg[1];
      pin_fall = pin_prev_reg && !pin_level;
      alt_route = ctrl_in.dual_clock_out_en && ctrl_in.clock_out_pin_sel;
   end

   // Transfer sequencer, shifters and flags
   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      div_cnt_next = div_cnt_reg;
      clk_act_next = clk_act_reg;
      sampled_next = sampled_reg;
      tx_shift_next = tx_shift_reg;
      rx_shift_next = rx_shift_reg;
      rx_buf_next = rx_buf_reg;
      serial_out_next = serial_out_reg;
      rx_complete_next = rx_complete_reg && !rx_read_in;
      overrun_next = overrun_reg;
      tx_irq_next = tx_irq_reg && !tx_irq_clear_in;
      rx_irq_next = rx_irq_reg && !rx_irq_clear_in;
      rrm_pending_next = rrm_pending_reg;
      rts_next = rts_reg;
      // A read in continuous mode marks the transmit buffer as holding data
      if (rx_read_in && ctrl_in.continuous_rx_sel) begin
         rrm_pending_next = 1'b1;
      end
      case (state_reg)
         ST_IDLE: begin
            div_cnt_next = DIV_COUNT_RESET;
            if (start_ok) begin
               state_next = ST_SHIFT;
               bit_cnt_next = FIRST_BIT_COUNT;
               tx_shift_next = load_data;
               serial_out_next = load_data[bit_index(FIRST_BIT_COUNT,
                                                     ctrl_in.bit_order_sel)];
               clk_act_next = internal;
               sampled_next = 1'b0;
               if (!fifo_valid) begin
                  rrm_pending_next = rx_read_in && ctrl_in.continuous_rx_sel;
               end
               if (!ctrl_in.tx_irq_source_sel) begin
                  tx_irq_next = 1'b1;
               end
            end
         end
         ST_SHIFT: begin
            if (internal && count_source_tick_in) begin
               div_cnt_next = half_done ? DIV_COUNT_RESET : 8'(div_cnt_reg + 8'h01);
            end
            if (half_done) begin
               clk_act_next = !clk_act_reg;
            end
            // The first external drive edge only confirms the bit already out
            if (drive_evt && sampled_reg) begin
               bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
               serial_out_next = tx_shift_reg[bit_index(3'(bit_cnt_reg + 3'h1),
                                                        ctrl_in.bit_order_sel)];
               sampled_next = 1'b0;
            end
            if (sample_evt) begin
               sampled_next = 1'b1;
               rx_shift_next[bit_index(bit_cnt_reg, ctrl_in.bit_order_sel)] =
                  sync2_reg[0];
               if (bit_cnt_reg == OVERRUN_BIT_COUNT && rx_complete_reg && !rx_read_in &&
                   ctrl_in.rx_enable) begin
                  overrun_next = 1'b1;
               end
               if (bit_cnt_reg == LAST_BIT_COUNT) begin
                  state_next = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
            serial_out_next = SERIAL_OUT_RESET;
            if (ctrl_in.rx_enable) begin
               rx_buf_next = rx_shift_reg;
               rx_complete_next = 1'b1;
               rx_irq_next = 1'b1;
            end
            if (ctrl_in.tx_irq_source_sel) begin
               tx_irq_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // RTS rises at the first falling clock edge, falls again once ready
      if (pin_fall) begin
         rts_next = 1'b1;
      end else if (mode_on && ctrl_in.rx_enable && !rx_complete_reg &&
                   state_reg == ST_IDLE) begin
         rts_next = 1'b0;
      end
      // Mode off abandons the character and empties both buffers
      if (!mode_on) begin
         state_next = ST_IDLE;
         clk_act_next = 1'b0;
         serial_out_next = SERIAL_OUT_RESET;
         rx_complete_next = 1'b0;
         overrun_next = 1'b0;
         rrm_pending_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= FIRST_BIT_COUNT;
         div_cnt_reg <= DIV_COUNT_RESET;
         clk_act_reg <= 1'b0;
         sampled_reg <= 1'b0;
         tx_shift_reg <= DATA_RESET;
         rx_shift_reg <= DATA_RESET;
         rx_buf_reg <= DATA_RESET;
         serial_out_reg <= SERIAL_OUT_RESET;
         rx_complete_reg <= 1'b0;
         overrun_reg <= 1'b0;
         tx_irq_reg <= 1'b0;
         rx_irq_reg <= 1'b0;
         rrm_pending_reg <= 1'b0;
         rts_reg <= RTS_RESET;
         ext_act_prev_reg <= 1'b0;
         pin_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         div_cnt_reg <= div_cnt_next;
         clk_act_reg <= clk_act_next;
         sampled_reg <= sampled_next;
         tx_shift_reg <= tx_shift_next;
         rx_shift_reg <= rx_shift_next;
         rx_buf_reg <= rx_buf_next;
         serial_out_reg <= serial_out_next;
         rx_complete_reg <= rx_complete_next;
         overrun_reg <= overrun_next;
         tx_irq_reg <= tx_irq_next;
         rx_irq_reg <= rx_irq_next;
         rrm_pending_reg <= rrm_pending_next;
         rts_reg <= rts_next;
         ext_act_prev_reg <= ext_act;
         pin_prev_reg <= pin_level;
      end
   end

   // Pins: alternate clock pin holds the idle level unless selected
   assign serial_clock_pin_out = gen_level;
   assign serial_clock_pin_oe_out = internal && !alt_route;
   assign serial_clock_alt_out = alt_route ? gen_level : !ctrl_in.clock_polarity_sel;
   assign serial_clock_alt_oe_out = internal && ctrl_in.dual_clock_out_en;
   assign serial_out_pin_out = serial_out_reg;
   assign flow_control_pin_out = rts_reg;
   assign flow_control_pin_oe_out = rts_used;
   assign flow_peer_disable_out = ctrl_in.split_flow_pins_sel;
   assign rx_buffer_out = rx_buf_reg ^ {DATA_W{ctrl_in.data_invert_sel}};

   // Status bits
   assign status_out.tx_buffer_empty_flag = !data_present;
   assign status_out.shift_reg_empty_flag = (state_reg == ST_IDLE);
   assign status_out.rx_complete_flag = rx_complete_reg;
   assign status_out.overrun_flag = overrun_reg;
   assign status_out.tx_irq_request_flag = tx_irq_reg;
   assign status_out.rx_irq_request_flag = rx_irq_reg;

   // Checks on the sequencer and pins
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n);

   property p_idle_clock_low;
      (state_reg == ST_IDLE) && internal && ctrl_in.clock_polarity_sel && !alt_route
         |-> !serial_clock_pin_out && serial_clock_pin_oe_out;
   endproperty
   a_idle_clock_low: assert property (p_idle_clock_low) else $error("idle clock not low");

   property p_start_needs_cts;
      (state_reg == ST_IDLE) ##1 (state_reg == ST_SHIFT)
         |-> $past(ctrl_in.tx_enable) && !($past(cts_used) && $past(cts_high));
   endproperty
   a_start_needs_cts: assert property (p_start_needs_cts) else $error("bad start");

   property p_first_bit;
      fifo_pop |=> serial_out_reg == ($past(ctrl_in.data_invert_sel) ^
         ($past(ctrl_in.bit_order_sel) ? $past(fifo_data[7]) : $past(fifo_data[0])));
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first bit wrong");

   property p_rx_done;
      (state_reg == ST_DONE) && ctrl_in.rx_enable && mode_on
         |=> rx_complete_reg && rx_irq_reg && rx_buf_reg == $past(rx_shift_reg);
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("receive completion lost");

   property p_cont_read;
      rx_read_in && ctrl_in.continuous_rx_sel && mode_on
         |=> !status_out.tx_buffer_empty_flag;
   endproperty
   a_cont_read: assert property (p_cont_read) else $error("read did not rearm");

   property p_rts_fall;
      pin_fall && rts_used |=> flow_control_pin_out ##1 1'b1;
   endproperty
   a_rts_fall: assert property (p_rts_fall) else $error("rts not raised");

   property p_tx_irq_load;
      fifo_pop && !ctrl_in.tx_irq_source_sel |=> tx_irq_reg;
   endproperty
   a_tx_irq_load: assert property (p_tx_irq_load) else $error("tx request missing");

   property p_irq_hold;
      tx_irq_reg && !tx_irq_clear_in |=> tx_irq_reg;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("tx request dropped");

   property p_overrun;
      sample_evt && bit_cnt_reg == OVERRUN_BIT_COUNT && rx_complete_reg && !rx_read_in &&
         ctrl_in.rx_enable && mode_on |=> overrun_reg;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_alt_clock;
      internal && alt_route |-> serial_clock_alt_out == gen_level && serial_clock_alt_oe_out;
   endproperty
   a_alt_clock: assert property (p_alt_clock) else $error("alternate clock wrong");

   c_transfer_done: cover property ((state_reg == ST_SHIFT) ##[1:1000] (state_reg == ST_DONE));
   c_overrun: cover property ($rose(overrun_reg));
   c_cont_start: cover property (rrm_pending_reg && start_ok);
   c_cts_blocked: cover property (mode_on && ctrl_in.tx_enable && data_present && cts_used &&
                                  cts_high && state_reg == ST_IDLE);
endmodule
`default_nettype wire

// ### serial_channel_pkg.sv
// Shared constants, states and carrier structs for the clocked serial channel.
// Assumes a single system clock domain; all pins are synchronised in the top.
`default_nettype none
package serial_channel_pkg;
   // Mode field encodings
   localparam logic [2:0] MODE_DISABLED = 3'h0;
   localparam logic [2:0] MODE_SYNC = 3'h1;
   // Character framing
   localparam int CHAR_BITS = 8;
   localparam int TX_FIFO_DEPTH = 4;
   localparam logic [2:0] FIRST_BIT_COUNT = 3'h0;
   localparam logic [2:0] LAST_BIT_COUNT = 3'h7;
   localparam logic [2:0] OVERRUN_BIT_COUNT = 3'h6;
   localparam logic [7:0] DUMMY_TX_DATA = 8'hff;
   localparam logic [7:0] DIV_COUNT_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Levels after reset
   localparam logic SERIAL_OUT_RESET = 1'b1;
   localparam logic RTS_RESET = 1'b1;
   localparam logic [3:0] SYNC_RESET = 4'hf;

   // Gray codes along idle, shift, done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE = 2'b11
   } xfer_state_e;

   // Software control bits
   typedef struct packed {
      logic [2:0] serial_mode_field;
      logic clock_source_dir;
      logic clock_polarity_sel;
      logic bit_order_sel;
      logic data_invert_sel;
      logic continuous_rx_sel;
      logic tx_irq_source_sel;
      logic flow_ctrl_disable;
      logic flow_ctrl_dir_sel;
      logic split_flow_pins_sel;
      logic dual_clock_out_en;
      logic clock_out_pin_sel;
      logic tx_enable;
      logic rx_enable;
   } ctrl_s;

   // Status seen by software
   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic shift_reg_empty_flag;
      logic rx_complete_flag;
      logic overrun_flag;
      logic tx_irq_request_flag;
      logic rx_irq_request_flag;
   } status_s;
endpackage
`default_nettype wire

// ### tx_word_fifo.sv
// Small synchronous FIFO holding transmit characters ahead of the shifter.
// Assumes writer and reader share the clock; flush empties it in one cycle.
`default_nettype none
module tx_word_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] DEPTH_CNT = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [CNT_W-1:0] count_reg, count_next;
   logic push, pop;

   // Pointer wrap without assuming a power-of-two depth
   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
   endfunction

   // Honest full and empty from the occupancy count
   assign in_ready_out = (count_reg != DEPTH_CNT);
   assign out_valid_out = (count_reg != '0);
   assign out_data_out = mem_reg[rd_ptr_reg];
   assign push = in_valid_in && in_ready_out && !flush_in;
   assign pop = out_valid_out && out_ready_in && !flush_in;

   // Next pointers and count
   always_comb begin
      wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
      rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
      count_next = CNT_W'(count_reg + CNT_W'(push) - CNT_W'(pop));
      if (flush_in) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         count_next = '0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // Storage needs no reset; empty slots are never read out as valid
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end
endmodule
`default_nettype wire

// ### serial_partner_model.sv
// Far-side serial partner clocked by the channel's clock pin.
// Assumes the channel drives the clock; the bench sets polarity and order.
`default_nettype none
module serial_partner_model (
   input wire logic sck_in,
   input wire logic pol_in,
   input wire logic msb_in,
   input wire logic clr_in,
   input wire logic [7:0] tx_byte_in,
   input wire logic sdo_in,
   output logic sdi_out,
   output logic [7:0] rx_byte_out
);
   timeunit 1ns;
   timeprecision 100ps;
   int idx = 0;
   initial sdi_out = 1'b0;
   initial rx_byte_out = 8'h00;
   // Polarity changes make stray edges, so the bench restarts the count
   always @(posedge clr_in) idx = 0;
   // Drive on one edge, sample on the other
   always @(sck_in) begin
      if (idx < 8 && sck_in === pol_in) begin
         sdi_out = tx_byte_in[msb_in ? 7 - idx : idx];
      end else if (idx < 8 && sck_in === ~pol_in) begin
         rx_byte_out[msb_in ? 7 - idx : idx] = sdo_in;
         idx++;
         if (idx == 8) begin
            idx = 0;
            sdi_out <= ~sdi_out; // Released line must not keep the last bit
         end
      end
   end
endmodule
`default_nettype wire

// ### clock_sync_serial_channel_tb.sv
// Self-checking bench for the clocked serial channel and its partner.
// Assumes internal clock and one count tick per system cycle.
`default_nettype none
module clock_sync_serial_channel_tb;
   import serial_channel_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] DIV = 8'h03;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wv = 1'b0, rd = 1'b0, cts = 1'b1, clr = 1'b0;
   logic [7:0] wd = 8'h00, pb = 8'h00, prx, rxb;
   logic sck, sck_oe, so, si, rts, rts_oe, alt, alt_oe, peer, rdy;
   ctrl_s ctrl = '0;
   status_s st;
   int n_fail = 0, n_checks = 0, cyc = 0;
   clock_sync_serial_channel #(.DATA_W(8), .FIFO_DEPTH(4)) i_dut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ctrl_in(ctrl),
      .bit_rate_divider_in(DIV), .count_source_tick_in(1'b1),
      .tx_write_valid_in(wv), .tx_write_data_in(wd), .tx_write_ready_out(rdy),
      .rx_read_in(rd), .rx_buffer_out(rxb), .tx_irq_clear_in(rd), .rx_irq_clear_in(rd),
      .status_out(st), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck),
      .serial_clock_pin_oe_out(sck_oe), .serial_clock_alt_out(alt),
      .serial_clock_alt_oe_out(alt_oe), .serial_out_pin_out(so), .serial_in_pin_in(si),
      .flow_control_pin_in(cts), .flow_control_pin_out(rts), .flow_control_pin_oe_out(rts_oe),
      .flow_cts_alt_in(cts), .flow_peer_disable_out(peer));
   serial_partner_model i_partner (.sck_in(sck), .pol_in(ctrl.clock_polarity_sel),
      .msb_in(ctrl.bit_order_sel), .clr_in(clr), .tx_byte_in(pb), .sdo_in(so),
      .sdi_out(si), .rx_byte_out(prx));
   // 40 MHz system clock
   initial forever #12.5 clk_sys_in = ~clk_sys_in;
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, far above the planned run length
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #2;
   endtask
   task automatic base();
      ctrl = '0;
      ctrl.serial_mode_field = MODE_SYNC;
      ctrl.flow_ctrl_dir_sel = 1'b1;
      ctrl.tx_enable = 1'b1;
      ctrl.rx_enable = 1'b1;
   endtask
   // Lets the idle clock level settle before the partner restarts its count
   task automatic settle();
      tick(3);
      clr = 1'b1;
      #1 clr = 1'b0;
   endtask
   task automatic push(input logic [7:0] d);
      wv = 1'b1;
      wd = d;
      tick(1);
      wv = 1'b0;
   endtask
   // Waits out one character, then checks both directions and the flags
   task automatic finish(input logic [7:0] t, input logic [7:0] p, input logic r, input logic ov);
      int w;
      w = 0;
      while (st.shift_reg_empty_flag === 1'b1 && w < 200) begin
         tick(1);
         w++;
      end
      w = 8;
      tick(8);
      if (ctrl.flow_ctrl_dir_sel) check(rts, 1'b1);
      check(st.tx_irq_request_flag, !ctrl.tx_irq_source_sel);
      while (st.shift_reg_empty_flag !== 1'b1 && w < 300) begin
         tick(1);
         w++;
      end
      // Eight sampling edges span fifteen half periods, then one completion cycle
      check(8'(w), 8'(15 * (DIV + 1) + 1));
      check(prx, t ^ {8{ctrl.data_invert_sel}});
      if (!ov) check(rxb, p ^ {8{ctrl.data_invert_sel}});
      check({st.rx_complete_flag, st.rx_irq_request_flag, st.tx_irq_request_flag,
         st.overrun_flag}, {3'h7, ov});
      check(sck, !ctrl.clock_polarity_sel);
      if (r) begin
         rd = 1'b1;
         tick(1);
         rd = 1'b0;
         check({st.rx_complete_flag, st.rx_irq_request_flag, st.tx_irq_request_flag,
            st.tx_buffer_empty_flag}, {3'h0, ~ctrl.continuous_rx_sel});
      end
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_in);
      #2 rst_n_in = 1'b1;
      tick(3);
      base();
      ctrl.dual_clock_out_en = 1'b1;
      ctrl.clock_out_pin_sel = 1'b1;
      tick(1);
      check({alt_oe, sck_oe, alt}, 3'h5);
      // Split flow pins want the dual clock output off
      ctrl.dual_clock_out_en = 1'b0;
      ctrl.split_flow_pins_sel = 1'b1;
      tick(1);
      check({alt_oe, sck_oe, peer, rts_oe}, 4'h7);
      // Every polarity, bit order and inversion setting
      for (int k = 0; k < 8; k++) begin
         base();
         {ctrl.data_invert_sel, ctrl.bit_order_sel, ctrl.clock_polarity_sel} = k[2:0];
         settle();
         check({rts, rts_oe}, 2'h1);
         pb = 8'h3c + 8'(k);
         push(8'ha1 ^ 8'(k * 37));
         finish(8'ha1 ^ 8'(k * 37), pb, 1'b1, 1'b0);
      end
      // Clear-to-send high and transmit disabled both hold the start back
      base();
      ctrl.flow_ctrl_dir_sel = 1'b0;
      ctrl.tx_enable = 1'b0;
      ctrl.tx_irq_source_sel = 1'b1;
      settle();
      push(8'h5a);
      tick(20);
      check(st.shift_reg_empty_flag, 1'b1);
      ctrl.tx_enable = 1'b1;
      tick(20);
      check(st.shift_reg_empty_flag, 1'b1);
      cts = 1'b0;
      finish(8'h5a, pb, 1'b1, 1'b0);
      // Back-to-back characters with no read in between
      base();
      settle();
      // Valid stays up across both writes so it never toggles twice in a step
      wv = 1'b1;
      wd = 8'h81;
      tick(1);
      wd = 8'h7e;
      tick(1);
      wv = 1'b0;
      finish(8'h81, pb, 1'b0, 1'b0);
      finish(8'h7e, pb, 1'b1, 1'b1);
      // Reinit sequence; mode off also drops the stale overrun
      ctrl.rx_enable = 1'b0;
      tick(1);
      ctrl.serial_mode_field = MODE_DISABLED;
      tick(1);
      check(st.overrun_flag, 1'b0);
      ctrl.serial_mode_field = MODE_SYNC;
      tick(1);
      ctrl.rx_enable = 1'b1;
      // Continuous receive: the dummy read alone starts a character
      ctrl.continuous_rx_sel = 1'b1;
      settle();
      pb = 8'hc9;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      check(st.tx_buffer_empty_flag, 1'b0);
      finish(DUMMY_TX_DATA, pb, 1'b1, 1'b0);
      wrap_up();
   end
endmodule
`default_nettype wire
